// File: dca_datapath.sv
// arithmetic unit, accumulator, carry/overflow and aux register file
`timescale 1ns/10ps
module dca_datapath
  import dca_pkg::*;
(
  input  wire logic                 clk_in,
  input  wire logic                 rst_in,
  input  wire logic                 op_valid_in,
  input  wire dca_op_t              op_in,
  input  wire dca_src_t             src_in,
  input  wire logic [3:0]           scale_in,
  input  wire logic [15:0]          data_in,
  input  wire logic [31:0]          product_holder_in,
  input  wire logic [15:0]          temporary_operand_reg_in,
  input  wire logic [3:0]           bit_num_in,
  input  wire logic                 bit_test_by_operand_reg_in,
  input  wire logic [2:0]           store_shift_in,
  input  wire logic                 saturate_enable_in,
  input  wire logic                 sign_extension_select_in,
  input  wire logic                 overflow_clear_in,
  input  wire dca_aux_op_t          aux_op_in,
  input  wire dca_aux_src_t         aux_src_in,
  input  wire logic [AUX_SEL_W-1:0] aux_index_in,
  input  wire logic [15:0]          aux_imm_in,
  output logic [31:0]               main_sum_register_out,
  output logic                      carry_out,
  output logic [15:0]               status_word_one_out,
  output logic                      branch_if_overflowed_out,
  output logic                      branch_if_accum_zero_out,
  output logic                      branch_take_out,
  output logic [15:0]               branch_target_out,
  output logic                      bit_test_out,
  output logic [15:0]               store_data_out,
  output logic [AUX_SEL_W-1:0]      aux_reg_select_out,
  output logic [15:0]               aux_addr_out,
  output logic [15:0]               aux_read_out
);

  // ============================================================
  // operand selection and arithmetic
  logic [31:0] accum;
  logic        carry;
  logic        ovf_flag;
  logic [15:0] aux_regs [AUX_N];
  logic [AUX_SEL_W-1:0] aux_sel;
  logic [31:0] data_ext;
  logic [31:0] operand;
  logic [32:0] sum;
  logic        is_add;
  logic        is_sub;
  logic        cin;
  logic        overflow;
  logic [31:0] next_accum;
  logic        next_carry;

  // data sign-extends only when sign extension mode is on
  assign data_ext = sign_extension_select_in ?
                    {{HALF{data_in[15]}}, data_in} : {{HALF{1'b0}}, data_in};

  always_comb begin
    case (src_in)
      SRC_PRODUCT: operand = product_holder_in;
      SRC_DATA:    operand = data_ext << scale_in;
      SRC_ACCUM:   operand = accum << scale_in;
      default:     operand = {{HALF{1'b0}}, aux_regs[aux_index_in]};
    endcase
    if (op_in == OP_ADD_HI || op_in == OP_SUB_HI) begin
      operand = {data_in, 16'h0000};
    end
  end

  assign is_add = op_in == OP_ADD || op_in == OP_ADD_HI || op_in == OP_ADD_CARRY;
  assign is_sub = op_in == OP_SUB || op_in == OP_SUB_HI || op_in == OP_SUB_BORROW;

  // subtraction as a + ~b + 1, so the carry-out already means no borrow
  always_comb begin
    case (op_in)
      OP_ADD_CARRY:  cin = carry;
      OP_SUB_BORROW: cin = carry;
      default:       cin = is_sub;
    endcase
  end

  assign sum = {1'b0, accum} + {1'b0, is_sub ? ~operand : operand} + {32'h0000_0000, cin};

  // signed overflow from operand signs, logic ops excluded
  assign overflow = (is_add && accum[31] == operand[31] && sum[31] != accum[31]) ||
                    (is_sub && accum[31] != operand[31] && sum[31] != accum[31]);

  // ============================================================
  // accumulator and carry next values
  always_comb begin
    next_accum = accum;
    next_carry = carry;
    case (op_in)
      OP_LOAD: next_accum = operand;
      OP_ADD, OP_SUB, OP_ADD_CARRY, OP_SUB_BORROW: begin
        next_accum = sum[31:0];
        next_carry = sum[32];
      end
      OP_ADD_HI: begin
        next_accum = sum[31:0];
        if (sum[32]) begin
          next_carry = 1'b1;
        end
      end
      OP_SUB_HI: begin
        next_accum = sum[31:0];
        if (!sum[32]) begin
          next_carry = 1'b0;
        end
      end
      OP_AND: next_accum = accum & operand;
      OP_OR:  next_accum = accum | operand;
      OP_XOR: next_accum = accum ^ operand;
      OP_SHL: begin
        next_accum = {accum[30:0], 1'b0};
        next_carry = accum[31];
      end
      OP_SHR: begin
        next_accum = {sign_extension_select_in & accum[31], accum[31:1]};
        next_carry = accum[0];
      end
      OP_ROTL: begin
        next_accum = {accum[30:0], carry};
        next_carry = accum[31];
      end
      OP_ROTR: begin
        next_accum = {carry, accum[31:1]};
        next_carry = accum[0];
      end
      default: next_accum = accum;
    endcase
    if (overflow && saturate_enable_in) begin
      next_accum = accum[31] ? SAT_NEG : SAT_POS;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      accum <= SUM_RST;
    end else if (op_valid_in) begin
      accum <= next_accum;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      carry <= CARRY_RST;
    end else if (op_valid_in) begin
      carry <= next_carry;
    end
  end

  // set wins over a clear arriving in the same cycle
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ovf_flag <= 1'b0;
    end else if (op_valid_in && overflow) begin
      ovf_flag <= 1'b1;
    end else if (overflow_clear_in) begin
      ovf_flag <= 1'b0;
    end
  end

  // ============================================================
  // store path, branch target, bit test
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      store_data_out <= 16'h0000;
    end else if (op_valid_in && op_in == OP_STORE_HI) begin
      store_data_out <= 16'((accum << store_shift_in) >> HALF);
    end else if (op_valid_in && op_in == OP_STORE_LO) begin
      store_data_out <= accum[15:0] << store_shift_in;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      branch_take_out   <= 1'b0;
      branch_target_out <= 16'h0000;
    end else begin
      branch_take_out <= op_valid_in && op_in == OP_BRANCH_ACC;
      if (op_valid_in && op_in == OP_BRANCH_ACC) begin
        branch_target_out <= accum[15:0];
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      bit_test_out <= 1'b0;
    end else if (op_valid_in && op_in == OP_BIT_TEST) begin
      bit_test_out <= bit_test_by_operand_reg_in ?
                      data_in[temporary_operand_reg_in[3:0]] :
                      data_in[bit_num_in];
    end
  end

  // ============================================================
  // aux register file and index unit
  logic [15:0] aux_load;
  logic [15:0] aux_cur;
  logic [15:0] next_aux_cur;

  always_comb begin
    case (aux_src_in)
      AUX_FROM_DATA:    aux_load = data_in;
      AUX_FROM_ACCUM:   aux_load = accum[15:0];
      AUX_FROM_PRODUCT: aux_load = product_holder_in[15:0];
      default:          aux_load = aux_imm_in;
    endcase
  end

  assign aux_cur = aux_regs[aux_sel];

  // own adder so the main unit stays free
  always_comb begin
    case (aux_op_in)
      AUX_INC:  next_aux_cur = aux_cur + 16'h0001;
      AUX_DEC:  next_aux_cur = aux_cur - 16'h0001;
      AUX_ADD0: next_aux_cur = aux_cur + aux_regs[0];
      AUX_SUB0: next_aux_cur = aux_cur - aux_regs[0];
      default:  next_aux_cur = aux_cur;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      aux_sel <= '0;
    end else if (aux_op_in == AUX_LOAD_SEL) begin
      aux_sel <= aux_load[AUX_SEL_W-1:0];
    end
  end

  for (genvar i = 0; i < AUX_N; i++) begin : g_aux
    always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
        aux_regs[i] <= AUX_RST;
      end else if (aux_op_in == AUX_LOAD && aux_index_in == AUX_SEL_W'(i)) begin
        aux_regs[i] <= aux_load;
      end else if (aux_sel == AUX_SEL_W'(i) && aux_op_in != AUX_LOAD) begin
        aux_regs[i] <= next_aux_cur;
      end
    end
  end

  // ============================================================
  // outputs
  assign main_sum_register_out    = accum;
  assign carry_out                = carry;
  assign status_word_one_out      = 16'(carry) << CARRY_BIT;
  assign branch_if_overflowed_out = ovf_flag;
  assign branch_if_accum_zero_out = accum == SUM_RST;
  assign aux_reg_select_out       = aux_sel;
  assign aux_addr_out             = aux_cur;
  assign aux_read_out             = aux_regs[aux_index_in];

  // ============================================================
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sat_clamp_a: assert property (op_valid_in && overflow && saturate_enable_in |=>
    accum == ($past(accum[31]) ? SAT_NEG : SAT_POS)) else $error("saturation value wrong");
  wrap_keep_a: assert property (op_valid_in && overflow && !saturate_enable_in |=>
    accum == $past(sum[31:0]) && ovf_flag) else $error("wrapped result wrong");
  logic_ovf_a: assert property (op_valid_in && op_in inside {OP_AND, OP_OR, OP_XOR}
    && !ovf_flag |=> !ovf_flag) else $error("logic op flagged overflow");
  carry_add_a: assert property (op_valid_in && op_in == OP_ADD |=>
    carry == $past(sum[32])) else $error("carry after add wrong");
  carry_hi_a: assert property (op_valid_in && op_in == OP_SUB_HI && sum[32] |=>
    $stable(carry)) else $error("carry changed on shift-16 sub");
  shift_left_a: assert property (op_valid_in && op_in == OP_SHL |=>
    carry == $past(accum[31]) && !accum[0]) else $error("left shift wrong");
  shift_right_a: assert property (op_valid_in && op_in == OP_SHR |=>
    accum[31] == ($past(sign_extension_select_in) & $past(accum[31])))
    else $error("right shift fill wrong");
  bit_keep_a: assert property (op_valid_in && op_in == OP_BIT_TEST |=>
    $stable(accum)) else $error("bit test changed accumulator");
  branch_tgt_a: assert property (op_valid_in && op_in == OP_BRANCH_ACC |=>
    branch_take_out && branch_target_out == $past(accum[15:0])) else $error("branch target");
  aux_step_a: assert property (aux_op_in == AUX_INC |=>
    aux_regs[$past(aux_sel)] == $past(aux_cur) + 16'h0001) else $error("aux step wrong");
  carry_sub_a: assert property (op_valid_in && op_in == OP_SUB |=>
    carry == $past(sum[32])) else $error("carry after subtract wrong");
  hi_add_keep_a: assert property (op_valid_in && op_in == OP_ADD_HI
    && !sum[32] |=> $stable(carry)) else $error("carry changed on shift-16 add");
  store_lo_a: assert property (op_valid_in && op_in == OP_STORE_LO
    && store_shift_in == 3'h0 |=> store_data_out == $past(accum[15:0]) && $stable(accum))
    else $error("unshifted low store wrong");
  ovf_wins_a: assert property (op_valid_in && overflow && overflow_clear_in |=>
    ovf_flag) else $error("overflow clear beat the set");
  rotate_right_a: assert property (op_valid_in && op_in == OP_ROTR |=>
    accum[31] == $past(carry) && carry == $past(accum[0])) else $error("right rotate wrong");

  sat_seen_c:  cover property (op_valid_in && overflow && saturate_enable_in);
  borrow_c:    cover property (op_valid_in && op_in == OP_SUB_BORROW && !carry);
  aux_add0_c:  cover property (aux_op_in == AUX_ADD0 ##1 aux_op_in == AUX_INC);
  hi_keep_c:   cover property (op_valid_in && op_in == OP_ADD_HI && !sum[32]);
  bit_opnd_c:  cover property (op_valid_in && op_in == OP_BIT_TEST && bit_test_by_operand_reg_in);

endmodule // dca_datapath

// File: dca_pkg.sv
// constants and types for the arithmetic datapath
// ============================================================
// Notes on behaviour
// - saturate_enable set: overflow sets flag and clamps accumulator result
// - clamp values are 7FFFFFFF for positive and 80000000 for negative overflow
// - saturate_enable clear: overflowed result wraps into accumulator, still flagged
// - logical operations never report overflow
// - overflow-taken and accumulator-zero branch conditions are provided
// - branch to accumulator takes the accumulator value as target
// - bit test on a data word, bit from instruction or operand reg, keeps accumulator
// - carry sits at bit 9 of status word one
// - add: carry equals carry-out; subtract: carry is cleared on borrow, else set
// - add/subtract shifted by 16 keep carry when no carry/no borrow
// - one-bit shifts and rotates go through carry, msb left, lsb right
// - hardware reset sets carry to one
// - add with carry and subtract with borrow use previous carry
// - accumulator stored as halves through 0 to 7 left shift, accumulator kept
// - shifted high half takes low bits from low half; low half zero-fills
// - right shift is arithmetic when sign_extension_select is 1, else logical
// - left shift always inserts zero at the lsb
// - eight aux_pointer_regs chosen by a 3-bit aux_reg_select
// - aux registers and pointer load from data, accumulator, product or immediate
// - address_index_unit steps selected register by one or by register zero
// - one arithmetic input is the accumulator, the other product, scaled data, scaled accumulator or an aux register
package dca_pkg;
  localparam int          SUM_W     = 32;
  localparam int          DATA_W    = 16;
  localparam int          AUX_N     = 8;
  localparam int          AUX_SEL_W = 3;
  localparam int          CARRY_BIT = 9;
  localparam int          HALF      = 16;
  localparam logic [31:0] SAT_POS   = 32'h7FFF_FFFF;
  localparam logic [31:0] SAT_NEG   = 32'h8000_0000;
  localparam logic [31:0] SUM_RST   = 32'h0000_0000;
  localparam logic [15:0] AUX_RST   = 16'h0000;
  localparam logic        CARRY_RST = 1'b1;

  typedef enum logic [4:0] {
    OP_NONE, OP_LOAD, OP_ADD, OP_SUB, OP_ADD_HI, OP_SUB_HI,
    OP_ADD_CARRY, OP_SUB_BORROW, OP_AND, OP_OR, OP_XOR,
    OP_SHL, OP_SHR, OP_ROTL, OP_ROTR, OP_BRANCH_ACC,
    OP_BIT_TEST, OP_STORE_HI, OP_STORE_LO
  } dca_op_t;

  typedef enum logic [1:0] {
    SRC_PRODUCT, SRC_DATA, SRC_ACCUM, SRC_AUX
  } dca_src_t;

  typedef enum logic [2:0] {
    AUX_NONE, AUX_LOAD, AUX_LOAD_SEL, AUX_INC, AUX_DEC, AUX_ADD0, AUX_SUB0
  } dca_aux_op_t;

  typedef enum logic [1:0] {
    AUX_FROM_DATA, AUX_FROM_ACCUM, AUX_FROM_PRODUCT, AUX_FROM_IMM
  } dca_aux_src_t;
endpackage

// File: dca_data_mem.sv
// data memory model that answers reads at the selected aux register address
`timescale 1ns/10ps
module dca_data_mem (
  input  wire logic [15:0] addr_in,
  output logic [15:0]      data_out
);
  // ==========================================
  // read path
  // every address gives its own word, so a wrong pointer shows at once
  assign data_out = {~addr_in[7:0], addr_in[15:8] ^ 8'h5a};
endmodule // dca_data_mem

// File: dca_datapath_bench.sv
// self-checking bench comparing the datapath with a reference model
`timescale 1ns/10ps
module dca_datapath_bench
  import dca_pkg::*;
;
  logic clk_in, rst_in = 1'b1, op_valid_in = 1'b0, by_opnd = 1'b0;
  logic sat = 1'b0, sign_ext = 1'b0, clr = 1'b0;
  dca_op_t      op   = OP_NONE;
  dca_src_t     src  = SRC_PRODUCT;
  dca_aux_op_t  aop  = AUX_NONE;
  dca_aux_src_t asrc = AUX_FROM_IMM;
  logic [2:0]   aidx = 3'h0, sh = 3'h0, sel;
  logic [3:0]   bnum = 4'h0, scl = 4'h0;
  logic [15:0]  opnd = 16'h0000, imm = 16'h0000, data, sw1, tgt, st, aaddr, aread;
  logic [31:0]  prod = 32'h0000_0000, sum_q, r, q;
  logic         c, ovf, zero, tk, bt;
  logic [31:0]  m_sum;
  logic [15:0]  m_ar [8];
  logic [15:0]  m_tgt, m_st;
  logic [2:0]   m_sel;
  logic         m_c, m_ovf, m_tk, m_bt;
  integer       error_cnt = 0, num_checks = 0, seed = 32'h6099801f, cyc = 0;
  dca_op_t ops [18] = '{OP_LOAD, OP_ADD, OP_SUB, OP_ADD_HI, OP_SUB_HI, OP_ADD_CARRY,
    OP_SUB_BORROW, OP_AND, OP_OR, OP_XOR, OP_SHL, OP_SHR, OP_ROTL, OP_ROTR,
    OP_BRANCH_ACC, OP_BIT_TEST, OP_STORE_HI, OP_STORE_LO};

  dca_datapath i_dut (.clk_in(clk_in), .rst_in(rst_in), .op_valid_in(op_valid_in),
    .op_in(op), .src_in(src), .scale_in(scl), .data_in(data),
    .product_holder_in(prod), .temporary_operand_reg_in(opnd), .bit_num_in(bnum),
    .bit_test_by_operand_reg_in(by_opnd), .store_shift_in(sh), .saturate_enable_in(sat),
    .sign_extension_select_in(sign_ext), .overflow_clear_in(clr), .aux_op_in(aop),
    .aux_src_in(asrc), .aux_index_in(aidx), .aux_imm_in(imm),
    .main_sum_register_out(sum_q), .carry_out(c), .status_word_one_out(sw1),
    .branch_if_overflowed_out(ovf), .branch_if_accum_zero_out(zero),
    .branch_take_out(tk), .branch_target_out(tgt), .bit_test_out(bt),
    .store_data_out(st), .aux_reg_select_out(sel), .aux_addr_out(aaddr),
    .aux_read_out(aread));
  dca_data_mem i_mem (.addr_in(aaddr), .data_out(data));

  // ==========================================
  // clock and watchdog
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      summarize();
    end
  end

  // ==========================================
  // checking helpers
  function automatic logic [15:0] mem_word(input logic [15:0] a);
    return {~a[7:0], a[15:8] ^ 8'h5a};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    if (error_cnt == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // one edge of operation and aux action, model first, then compare
  task automatic step(input logic v, input dca_op_t o, input dca_aux_op_t a);
    logic [32:0] s;
    logic [31:0] b, bb, na, t, dx;
    logic [15:0] d, av;
    logic hi, sub, ovn, nc;
    op_valid_in = v;
    op = o;
    aop = a;
    d = mem_word(m_ar[m_sel]);
    dx = sign_ext ? {{16{d[15]}}, d} : {16'h0000, d};
    hi = o inside {OP_ADD_HI, OP_SUB_HI};
    sub = o inside {OP_SUB, OP_SUB_HI, OP_SUB_BORROW};
    case (src)
      SRC_PRODUCT: b = prod;
      SRC_DATA:    b = dx << scl;
      SRC_ACCUM:   b = m_sum << scl;
      default:     b = {16'h0000, m_ar[aidx]};
    endcase
    if (hi) b = {d, 16'h0000};
    bb = sub ? ~b : b;
    s = {1'b0, m_sum} + {1'b0, bb} + ((o inside {OP_ADD_CARRY, OP_SUB_BORROW}) ? m_c : sub);
    ovn = v && (o inside {OP_ADD, OP_SUB, OP_ADD_HI, OP_SUB_HI, OP_ADD_CARRY, OP_SUB_BORROW})
          && m_sum[31] == bb[31] && s[31] != m_sum[31];
    case (asrc)
      AUX_FROM_DATA:    av = d;
      AUX_FROM_ACCUM:   av = m_sum[15:0];
      AUX_FROM_PRODUCT: av = prod[15:0];
      default:          av = imm;
    endcase
    na = m_sum;
    nc = m_c;
    t = m_sum << sh;
    m_tk = v && o == OP_BRANCH_ACC;
    if (v) begin
      case (o)
        OP_LOAD:       na = b;
        OP_AND:        na = m_sum & b;
        OP_OR:         na = m_sum | b;
        OP_XOR:        na = m_sum ^ b;
        OP_SHL:        {nc, na} = {m_sum, 1'b0};
        OP_SHR:        {na, nc} = {sign_ext & m_sum[31], m_sum};
        OP_ROTL:       {nc, na} = {m_sum, m_c};
        OP_ROTR:       {na, nc} = {m_c, m_sum};
        OP_BIT_TEST:   m_bt = d[by_opnd ? opnd[3:0] : bnum];
        OP_STORE_HI:   m_st = t[31:16];
        OP_STORE_LO:   m_st = t[15:0];
        OP_BRANCH_ACC: m_tgt = m_sum[15:0];
        OP_NONE:       ;
        default: begin
          na = (ovn && sat) ? (m_sum[31] ? SAT_NEG : SAT_POS) : s[31:0];
          nc = hi ? (sub ? (s[32] & m_c) : (s[32] | m_c)) : s[32];
        end
      endcase
    end
    case (a)
      AUX_LOAD:     m_ar[aidx] = av;
      AUX_LOAD_SEL: m_sel = av[2:0];
      AUX_INC:      m_ar[m_sel] = m_ar[m_sel] + 16'h0001;
      AUX_DEC:      m_ar[m_sel] = m_ar[m_sel] - 16'h0001;
      AUX_ADD0:     m_ar[m_sel] = m_ar[m_sel] + m_ar[0];
      AUX_SUB0:     m_ar[m_sel] = m_ar[m_sel] - m_ar[0];
      default:      ;
    endcase
    m_ovf = ovn | (m_ovf & ~clr);
    m_sum = na;
    m_c = nc;
    @(posedge clk_in);
    #1;
    chk(sum_q, m_sum);
    chk(c, m_c);
    chk(sw1, {6'h00, m_c, 9'h000});
    chk(ovf, m_ovf);
    chk(zero, m_sum == 32'h0000_0000);
    chk(tk, m_tk);
    chk(tgt, m_tgt);
    chk(bt, m_bt);
    chk(st, m_st);
    chk(sel, m_sel);
    chk(aaddr, m_ar[m_sel]);
    chk(aread, m_ar[aidx]);
  endtask

  // ==========================================
  // main sequence
  initial begin
    m_sum = SUM_RST;
    m_c = CARRY_RST;
    m_ovf = 1'b0;
    m_tk = 1'b0;
    m_bt = 1'b0;
    m_tgt = 16'h0000;
    m_st = 16'h0000;
    m_sel = 3'h0;
    foreach (m_ar[i]) m_ar[i] = AUX_RST;
    repeat (20) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    step(1'b0, OP_NONE, AUX_NONE);
    // saturation limits both ways, with and without clamping
    for (int k = 0; k < 4; k++) begin
      sat = k[0];
      prod = k[1] ? SAT_NEG : SAT_POS;
      step(1'b1, OP_LOAD, AUX_NONE);
      prod = 32'h0000_0001;
      step(1'b1, k[1] ? OP_SUB : OP_ADD, AUX_NONE);
      clr = 1'b1;
      step(1'b0, OP_NONE, AUX_NONE);
      clr = 1'b0;
    end
    // every store shift on both halves, then every aux register
    prod = 32'h9ac3_5e71;
    step(1'b1, OP_LOAD, AUX_NONE);
    for (int k = 0; k < 16; k++) begin
      sh = k[2:0];
      step(1'b1, k[3] ? OP_STORE_LO : OP_STORE_HI, AUX_NONE);
    end
    for (int k = 0; k < 8; k++) begin
      aidx = k[2:0];
      imm = 16'h1111 * k[15:0] + 16'h0003;
      step(1'b1, OP_BRANCH_ACC, AUX_LOAD);
    end
    repeat (400) begin
      r = $random(seed);
      q = $random(seed);
      prod = (q[31:28] == 4'h0) ? 32'h0000_0000 : $random(seed);
      imm = r[15:0];
      opnd = r[15:0];
      bnum = r[19:16];
      by_opnd = r[20];
      sh = r[23:21];
      sat = r[24];
      sign_ext = r[25];
      src = dca_src_t'(q[22:21]);
      scl = q[26:23];
      clr = r[28:26] == 3'h0;
      aidx = r[31:29];
      asrc = dca_aux_src_t'(q[1:0]);
      step(q[4:2] != 3'h0, ops[q[12:5] % 18], dca_aux_op_t'(q[20:13] % 7));
    end
    step(1'b0, OP_NONE, AUX_NONE);
    summarize();
  end
endmodule // dca_datapath_bench
